// >>> rtl/multi_variant_timer_unit.sv
// timer unit: prescaler, reload counter, channels, trigger link, apb registers
// Operation
// - wide variant: 32-bit up/down reload counter
// - narrow variant: 16-bit up/down reload counter
// - prescaler divides by one to 65536
// - four channels: capture, compare, pwm, one-pulse
// - pwm edge-aligned or center-aligned
// - complementary output pairs with dead time
// - pwm duty from fully off to on
// - counter may freeze during debug halt
// - timers linked by internal trigger
// - quadrature encoder and hall sensor inputs
// - each timer raises its own dma requests
// - basic variant: up only, no dma
// - single-channel variants add complementary dead-time output
`timescale 1ns/1ps
`include "timer_regs.svh"
module multi_variant_timer_unit
    import timer_pkg::*;
#(
    parameter int CNT_W     = 16,    // counter width, 16 or 32
    parameter int NUM_CH    = 4,     // channels in use, 1 to 4
    parameter int NUM_COMPL = 3,     // channels with a complementary pair
    parameter bit UPDOWN    = 1'b1,  // down and center counting present
    parameter bit DMA_EN    = 1'b1,  // dma requests present
    parameter bit ENC_EN    = 1'b1   // encoder and hall inputs present
) (
    // apb slave
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    // channel pins
    input  wire logic [`MAX_CH-1:0]  ch_in,
    output logic [`MAX_CH-1:0]       ch_out,
    output logic [`MAX_CH-1:0]       oc_p,
    output logic [`MAX_CH-1:0]       oc_n,
    // trigger link and debug
    input  wire logic                trig_in,
    output logic                     trig_out,
    input  wire logic                dbg_halt,
    // dma and interrupt
    output logic [`EVT_W-1:0]        dma_req,
    output logic                     irq
);

    // counter values above the width wrap; the mask keeps them in range
    localparam logic [31:0] CNT_MASK = 32'({CNT_W{1'b1}});

    timer_state_type  q, nx;       // registered state and its next value
    logic             tick;        // prescaled count enable
    logic             step;        // encoder count step
    logic             upd;         // update event
    logic             halted;      // frozen by debug halt
    logic             run;         // counter may advance
    logic             enc_up;      // encoder direction
    logic             go_down;     // direction of this step
    logic             wr;          // apb write access
    logic             trig_rise;   // link trigger edge
    logic             hall_edge;   // an odd number of hall lines changed
    logic [3:0]       rise;        // synced channel rising edges
    logic [3:0]       ev;          // channel events

    ////////////////////////////////////////////////////////////////////////
    // address decode, used by read, write and error paths
    function automatic logic is_ccr(input logic [7:0] a);
        return (a[7:4] == `CCR_BANK) && (int'(a[3:2]) < NUM_CH);
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        return (a[1:0] == 2'h0) && ((a <= `OFS_CHM) || is_ccr(a));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        nx   = q;
        wr   = psel & penable & pwrite & addr_ok(paddr);  // refused addresses never write
        ev   = 4'h0;
        upd  = 1'b0;
        tick = 1'b0;
        // channel pins cross two flops before anything looks at them
        nx.s1     = ch_in;
        nx.s2     = q.s1;
        nx.s3     = q.s2;
        rise      = q.s2 & ~q.s3;
        nx.trig_q = trig_in;
        trig_rise = trig_in & ~q.trig_q;
        halted    = q.frz & dbg_halt;
        run       = q.en & ~halted & ((q.smode != SM_GATED) | trig_in);
        // prescaler: count psc+1 clocks per tick
        if (run && q.smode != SM_ENCODER) begin
            // a smaller psc written mid-count must not stall for a full wrap
            if (q.pcnt >= q.psc) begin
                nx.pcnt = '0;
                tick    = 1'b1;
            end else begin
                nx.pcnt = q.pcnt + 16'h0001;
            end
        end
        // quadrature steps replace the prescaler in encoder mode
        enc_up  = q.s2[0] ^ q.s3[1];
        step    = ENC_EN && run && (q.smode == SM_ENCODER) && (q.s2[1:0] != q.s3[1:0]);
        go_down = (q.smode == SM_ENCODER) ? ~enc_up : q.down;
        // counter: center mode dwells one tick at each turn
        if (tick || step) begin
            if (!go_down) begin
                if (q.cnt == q.arr) begin
                    upd = 1'b1;
                    if (q.cmode == CM_CENTER && q.smode != SM_ENCODER) begin
                        nx.down = 1'b1;
                    end else begin
                        nx.cnt = '0;
                    end
                end else begin
                    nx.cnt = (q.cnt + 32'h1) & CNT_MASK;
                end
            end else begin
                if (q.cnt == '0) begin
                    upd = 1'b1;
                    if (q.cmode == CM_CENTER && q.smode != SM_ENCODER) begin
                        nx.down = 1'b0;
                    end else begin
                        nx.cnt = q.arr;
                    end
                end else begin
                    nx.cnt = q.cnt - 32'h1;
                end
            end
        end
        // link trigger restarts the count of a slave timer
        if (q.smode == SM_RESET && trig_rise) begin
            nx.cnt  = '0;
            nx.pcnt = '0;
        end
        // channel functions
        for (int i = 0; i < NUM_CH; i++) begin
            unique case (q.chm[i])
                CH_CAPTURE: begin
                    if (rise[i]) begin
                        nx.ccr[i] = q.cnt;
                        ev[i]     = 1'b1;
                    end
                end
                CH_COMPARE: begin
                    if ((tick || step) && q.cnt == q.ccr[i]) begin
                        nx.chq[i] = ~q.chq[i];
                        ev[i]     = 1'b1;
                    end
                end
                CH_PWM: begin
                    if ((tick || step) && q.cnt == q.ccr[i]) begin
                        ev[i] = 1'b1;
                    end
                end
                CH_OFF: begin
                    nx.chq[i] = 1'b0;
                end
            endcase
        end
        // hall sensors: a change on an odd number of lines captures the interval and restarts
        hall_edge = ENC_EN && q.hall && ((^q.s2[2:0]) != (^q.s3[2:0]));
        if (hall_edge) begin
            nx.ccr[0] = q.cnt;
            nx.cnt    = '0;
            ev[0]     = 1'b1;
        end
        // one-pulse: the update that ends the pulse stops the counter
        if (upd && q.opm) begin
            nx.en = 1'b0;
        end
        // apb read data is taken in the setup cycle
        if (psel && !penable) begin
            nx.rdata = 32'h0;
            if (addr_ok(paddr) && is_ccr(paddr)) begin
                nx.rdata = q.ccr[paddr[3:2]];
            end else begin
                case (paddr)
                    `OFS_CTRL: begin
                        nx.rdata[`CTRL_EN]    = q.en;
                        nx.rdata[`CTRL_MODE]  = q.cmode;
                        nx.rdata[`CTRL_OPM]   = q.opm;
                        nx.rdata[`CTRL_FRZ]   = q.frz;
                        nx.rdata[`CTRL_SMODE] = q.smode;
                        nx.rdata[`CTRL_HALL]  = q.hall;
                    end
                    `OFS_PSC: nx.rdata[`PSC_W-1:0] = q.psc;
                    `OFS_ARR: nx.rdata = q.arr;
                    `OFS_CNT: nx.rdata = q.cnt;
                    `OFS_STS: nx.rdata[`EVT_W-1:0] = q.sts;
                    `OFS_IEN: nx.rdata[`EVT_W-1:0] = q.ie;
                    `OFS_DEN: nx.rdata[`EVT_W-1:0] = q.de;
                    `OFS_DT:  nx.rdata[`DT_W-1:0] = q.dt;
                    `OFS_CHM: nx.rdata[`CHM_W-1:0] = q.chm;
                    default:  nx.rdata = 32'h0;
                endcase
            end
        end
        // apb writes take effect in the access cycle; status clears here
        if (wr && is_ccr(paddr)) begin
            nx.ccr[paddr[3:2]] = pwdata & CNT_MASK;
        end else if (wr) begin
            case (paddr)
                `OFS_CTRL: begin
                    nx.en    = pwdata[`CTRL_EN];
                    nx.opm   = pwdata[`CTRL_OPM];
                    nx.frz   = pwdata[`CTRL_FRZ];
                    nx.smode = ENC_EN ? slave_mode_type'(pwdata[`CTRL_SMODE]) : SM_OFF;
                    nx.hall  = ENC_EN & pwdata[`CTRL_HALL];
                    // variants without down counting stay up; 2'b11 is not a mode
                    if (!UPDOWN || pwdata[`CTRL_MODE] == 2'b11) begin
                        nx.cmode = CM_UP;
                    end else begin
                        nx.cmode = count_mode_type'(pwdata[`CTRL_MODE]);
                    end
                    nx.down = (nx.cmode == CM_DOWN);
                end
                `OFS_PSC: nx.psc = pwdata[`PSC_W-1:0];
                `OFS_ARR: nx.arr = pwdata & CNT_MASK;
                `OFS_CNT: nx.cnt = pwdata & CNT_MASK;
                `OFS_CLR: nx.sts = q.sts & ~pwdata[`EVT_W-1:0];
                `OFS_IEN: nx.ie  = pwdata[`EVT_W-1:0];
                `OFS_DEN: nx.de  = DMA_EN ? pwdata[`EVT_W-1:0] : 5'h00;
                `OFS_DT:  nx.dt  = pwdata[`DT_W-1:0];
                `OFS_CHM: begin
                    for (int i = 0; i < NUM_CH; i++) begin
                        nx.chm[i] = chan_mode_type'(pwdata[2*i +: 2]);
                    end
                end
                default: ;
            endcase
        end
        // events set after the clear, so a coincident event is kept
        nx.sts  = nx.sts | {ev, upd};
        nx.dma  = DMA_EN ? ({ev, upd} & q.de) : 5'h00;
        nx.trgo = upd;
        // pwm: ccr of zero is always off, above the reload always on
        for (int i = 0; i < NUM_CH; i++) begin
            if (nx.chm[i] == CH_PWM) begin
                nx.chq[i] = (nx.cnt < nx.ccr[i]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q     <= '0;
            q.arr <= `RST_ARR & CNT_MASK;
            // every channel starts switched off
            for (int i = 0; i < `MAX_CH; i++) begin
                q.chm[i] <= CH_OFF;
            end
        end else begin
            q <= nx;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata   = q.rdata;
    assign pready   = psel & penable;
    assign pslverr  = psel & penable & ~addr_ok(paddr);
    assign ch_out   = q.chq;
    assign trig_out = q.trgo;
    assign dma_req  = q.dma;
    assign irq      = |(q.sts & q.ie);

    // complementary pairs only on the channels that have them
    for (genvar g = 0; g < `MAX_CH; g++) begin : g_pair
        if (g < NUM_COMPL) begin : g_on
            dead_time_insert u_dead (
                .pclk        (pclk),
                .presetn     (presetn),
                .ref_level   (q.chq[g]),
                .dead_cycles (q.dt),
                .enable      (q.chm[g] != CH_OFF),
                .out_main    (oc_p[g]),
                .out_comp    (oc_n[g])
            );
        end else begin : g_off
            assign oc_p[g] = 1'b0;
            assign oc_n[g] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_up_wrap: assert property ((tick && !q.down && q.cmode == CM_UP && q.cnt == q.arr && !wr
        && q.smode == SM_OFF) |=> (q.cnt == 32'h0)) else $error("up count did not reload");
    a_down_reload: assert property ((tick && q.down && q.cmode == CM_DOWN && q.cnt == 32'h0
        && !wr && q.smode == SM_OFF && !hall_edge) |=> (q.cnt == $past(q.arr)))
        else $error("down count did not reload");
    a_update_flag: assert property (upd |=> (q.sts[0] && trig_out))
        else $error("update not flagged");
    a_presc_restart: assert property ((tick && !wr && !(q.smode == SM_RESET && trig_rise))
        |=> (q.pcnt == 16'h0000)) else $error("prescaler did not restart");
    a_freeze_hold: assert property ((halted && !wr && !hall_edge && !(q.smode == SM_RESET && trig_rise))
        |=> $stable(q.cnt)) else $error("counter moved while frozen");
    a_pwm_level: assert property ((q.chm[0] == CH_PWM) |-> (q.chq[0] == (q.cnt < q.ccr[0])))
        else $error("pwm level wrong");
    a_capture_value: assert property ((q.chm[0] == CH_CAPTURE && rise[0] && !hall_edge && !wr)
        |=> (q.ccr[0] == $past(q.cnt) && q.sts[1])) else $error("capture missed");
    a_opm_stop: assert property ((upd && q.opm && !wr) |=> !q.en)
        else $error("one-pulse did not stop");
    a_trig_reset: assert property ((q.smode == SM_RESET && trig_rise && !wr) |=> (q.cnt == 32'h0))
        else $error("trigger did not reset counter");
    a_dma_request: assert property (dma_req[0] |-> ($past(q.de[0]) && q.sts[0]))
        else $error("dma request without enabled update");
    a_no_dma: assert property (!DMA_EN |-> (dma_req == 5'h00))
        else $error("dma request on variant without dma");
    a_up_only: assert property (!UPDOWN |-> (q.cmode == CM_UP))
        else $error("up-only variant left up mode");

    c_update: cover property (upd ##1 irq);
    c_capture: cover property (q.chm[0] == CH_CAPTURE && rise[0]);
    c_center_turn: cover property (q.cmode == CM_CENTER && upd && go_down);
    c_encoder_step: cover property (step);

endmodule

// >>> rtl/timer_regs.svh
// register offsets, field positions, widths and reset values of the timer unit
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// register byte offsets
`define OFS_CTRL  8'h00
`define OFS_PSC   8'h04
`define OFS_ARR   8'h08
`define OFS_CNT   8'h0c
`define OFS_STS   8'h10
`define OFS_CLR   8'h14
`define OFS_IEN   8'h18
`define OFS_DEN   8'h1c
`define OFS_DT    8'h20
`define OFS_CHM   8'h24
// compare/capture bank: 0x30 + 4 * channel
`define CCR_BANK  4'h3

// control register fields
`define CTRL_EN    0
`define CTRL_MODE  2:1
`define CTRL_OPM   3
`define CTRL_FRZ   4
`define CTRL_SMODE 6:5
`define CTRL_HALL  7

// widths
`define MAX_CH 4
`define EVT_W  5
`define PSC_W  16
`define DT_W   8
`define CHM_W  8

// reset values
`define RST_ARR 32'hffff_ffff

`endif

// >>> rtl/timer_pkg.sv
// types shared by the timer unit and its dead-time stage
package timer_pkg;

    // counting direction modes
    typedef enum logic [1:0] {
        CM_UP     = 2'b00,
        CM_DOWN   = 2'b01,
        CM_CENTER = 2'b10
    } count_mode_type;

    // slave modes driven by the trigger link or the pins
    typedef enum logic [1:0] {
        SM_OFF     = 2'b00,
        SM_RESET   = 2'b01,
        SM_GATED   = 2'b10,
        SM_ENCODER = 2'b11
    } slave_mode_type;

    // per-channel function
    typedef enum logic [1:0] {
        CH_CAPTURE = 2'b00,
        CH_COMPARE = 2'b01,
        CH_PWM     = 2'b10,
        CH_OFF     = 2'b11
    } chan_mode_type;

    // whole state of the timer unit
    typedef struct packed {
        logic                           en;     // counter enable
        count_mode_type                 cmode;  // counting mode
        logic                           opm;    // one-pulse mode
        logic                           frz;    // freeze while halted
        slave_mode_type                 smode;  // slave mode
        logic                           hall;   // hall interface on
        logic [15:0]                    psc;    // prescale minus one
        logic [15:0]                    pcnt;   // prescale counter
        logic [31:0]                    arr;    // auto-reload value
        logic [31:0]                    cnt;    // counter
        logic                           down;   // counting down now
        logic [4:0]                     sts;    // sticky events
        logic [4:0]                     ie;     // interrupt enables
        logic [4:0]                     de;     // dma enables
        logic [4:0]                     dma;    // dma request pulses
        logic                           trgo;   // link trigger pulse
        logic [7:0]                     dt;     // dead-time cycles
        chan_mode_type [3:0]            chm;    // channel modes
        logic [3:0][31:0]               ccr;    // compare/capture values
        logic [3:0]                     chq;    // channel outputs
        logic [3:0]                     s1;     // pin sync stage one
        logic [3:0]                     s2;     // pin sync stage two
        logic [3:0]                     s3;     // previous synced level
        logic                           trig_q; // previous trigger level
        logic [31:0]                    rdata;  // read data
    } timer_state_type;

    // state of one dead-time stage
    typedef struct packed {
        logic [7:0] cnt;   // dead cycles still to wait
        logic       refq;  // last reference level
        logic       p;     // main output
        logic       n;     // complementary output
    } dead_state_type;

endpackage

// >>> rtl/dead_time_insert.sv
// dead-time stage: splits one reference into a complementary pair with a gap
`timescale 1ns/1ps
`include "timer_regs.svh"
module dead_time_insert
    import timer_pkg::*;
(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // reference and setting
    input  wire logic              ref_level,
    input  wire logic [`DT_W-1:0]  dead_cycles,
    input  wire logic              enable,
    // complementary pair
    output logic                   out_main,
    output logic                   out_comp
);

    dead_state_type q, nx;  // registered state and its next value

    ////////////////////////////////////////////////////////////////////////
    // both outputs drop on every reference edge, the new one rises after the gap
    always_comb begin
        nx = q;
        if (!enable) begin
            // idle pair is fully off so the power stage never floats half on
            nx.p    = 1'b0;
            nx.n    = 1'b0;
            nx.refq = ref_level;
            nx.cnt  = '0;
        end else if (ref_level != q.refq) begin
            nx.refq = ref_level;
            nx.cnt  = dead_cycles;
            nx.p    = 1'b0;
            nx.n    = 1'b0;
        end else if (q.cnt != '0) begin
            nx.cnt = q.cnt - 8'h01;
        end else begin
            nx.p = q.refq;
            nx.n = ~q.refq;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= nx;
        end
    end

    assign out_main = q.p;
    assign out_comp = q.n;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_no_overlap: assert property (@(posedge pclk) disable iff (!presetn)
        !(out_main && out_comp)) else $error("pair outputs both on");
    a_dead_gap: assert property (@(posedge pclk) disable iff (!presetn)
        (enable && $changed(ref_level)) |=> (!out_main && !out_comp))
        else $error("no dead gap after reference edge");
    c_dead_pair: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(out_main) ##[1:300] $rose(out_comp));

endmodule

// >>> tb/pin_partner.sv
// pin partner: quadrature encoder on the channel pins and a trigger line from a linked timer
`timescale 1ns/1ps
module pin_partner (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // commands from the bench
    input  wire logic       run,
    input  wire logic       reverse,
    input  wire logic       gate,
    // pins toward the timer
    output logic [3:0]      ch_in,
    output logic            trig_in
);
    logic [1:0] phase; // quadrature phase
    logic [1:0] div;   // one step each four clocks
    ////////////////////////////////////////////////////////////////////////
    // slow steps so that the two-flop pin sync never misses a phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 2'h0;
            div   <= 2'h0;
        end else if (run) begin
            div <= div + 2'h1;
            if (div == 2'h3) begin
                phase <= reverse ? phase - 2'h1 : phase + 2'h1;
            end
        end
    end
    // gray code: a on bit 0, b on bit 1; bits 2 and 3 stay low
    assign ch_in   = {2'h0, phase[1], phase[1] ^ phase[0]};
    assign trig_in = gate; // linked timer level
endmodule

// >>> tb/multi_variant_timer_unit_tb.sv
// self-checking bench of the timer unit: registers, counting, interrupt, pwm, hold, encoder
`timescale 1ns/1ps
`include "timer_regs.svh"
module multi_variant_timer_unit_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q, a;
    logic [3:0]  ch_in, ch_out, oc_p, oc_n;
    logic        trig_in, trig_out, dbg_halt, irq, run, rev, gate;
    logic [4:0]  dma_req;
    int          n_fail, comparisons;

    multi_variant_timer_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ch_in(ch_in), .ch_out(ch_out), .oc_p(oc_p), .oc_n(oc_n),
        .trig_in(trig_in), .trig_out(trig_out), .dbg_halt(dbg_halt), .dma_req(dma_req), .irq(irq));
    pin_partner pins (.pclk(pclk), .presetn(presetn), .run(run), .reverse(rev), .gate(gate),
        .ch_in(ch_in), .trig_in(trig_in));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic idle(input int c);
        repeat (c) @(negedge pclk);
    endtask
    // cycles between two update pulses, sampled at falling edges
    task automatic period(output int p);
        int n;
        n = 0;
        p = 0;
        do begin @(negedge pclk); n++; end while (trig_out !== 1'b1 && n < 200);
        chk("dma update", 1, dma_req[0]);
        do begin @(negedge pclk); p++; end while (trig_out !== 1'b1 && p < 200);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        apb(0, `OFS_ARR, 0); chk("arr reset", 32'h0000ffff, q);
        apb(0, `OFS_CHM, 0); chk("chm reset", 32'h000000ff, q);
        apb(0, 8'h28, 0); chk("unmapped err", 1, err);
        chk("unmapped data", 0, q);
        $display("test reset done");
    endtask
    // every counting mode at two prescale factors
    task t_count;
        int p;
        apb(1, `OFS_ARR, 2); apb(1, `OFS_DEN, 1);
        for (int m = 0; m < 3; m++) begin
            for (int s = 1; s < 4; s += 2) begin
                apb(1, `OFS_CTRL, 0); apb(1, `OFS_PSC, s); apb(1, `OFS_CNT, 0);
                apb(1, `OFS_CTRL, m * 2 + 1);
                period(p); chk("update period", (s + 1) * 3, p);
            end
        end
        $display("test count done");
    endtask
    // sticky status, mask, write-one clear, read-only status
    task t_irq;
        apb(1, `OFS_CTRL, 0); apb(1, `OFS_IEN, 0); idle(1);
        chk("irq masked", 0, irq);
        apb(1, `OFS_IEN, 1); idle(1); chk("irq set", 1, irq);
        apb(1, `OFS_STS, 0); apb(0, `OFS_STS, 0); chk("sts sticky", 1, q[0]);
        apb(1, `OFS_CLR, 1); idle(1); chk("irq cleared", 0, irq);
        apb(0, `OFS_STS, 0); chk("sts clear", 0, q);
        $display("test irq done");
    endtask
    // duty 0, half and full; complementary pair never both on
    task t_pwm;
        int h;
        apb(1, `OFS_CTRL, 0); apb(1, `OFS_ARR, 3); apb(1, `OFS_PSC, 0);
        apb(1, `OFS_CHM, 32'h000000fe); apb(1, `OFS_DT, 0); apb(1, `OFS_CTRL, 1);
        for (int i = 0; i < 5; i += 2) begin
            apb(1, 8'h30, i); idle(4);
            h = 0;
            repeat (8) begin
                @(negedge pclk);
                if (ch_out[0] === 1'b1) h++;
                chk("pair overlap", 0, oc_p[0] & oc_n[0]);
            end
            chk("pwm high cycles", i * 2, h);
        end
        $display("test pwm done");
    endtask
    // debug freeze, then gating by the linked trigger
    task t_hold;
        for (int k = 0; k < 2; k++) begin
            apb(1, `OFS_CTRL, 0); apb(1, `OFS_ARR, 32'h0000ffff);
            @(posedge pclk);
            dbg_halt <= (k == 0);
            gate <= 1'b0;
            apb(1, `OFS_CTRL, k ? 32'h41 : 32'h11); apb(0, `OFS_CNT, 0);
            a = q;
            idle(10); apb(0, `OFS_CNT, 0); chk("held count", a, q);
            @(posedge pclk);
            dbg_halt <= 1'b0;
            gate <= 1'b1;
            apb(0, `OFS_CNT, 0); chk("count moves", 1, q !== a);
        end
        $display("test hold done");
    endtask
    // ten steps forward then ten back
    task t_enc;
        apb(1, `OFS_CTRL, 0); apb(1, `OFS_CNT, 0); apb(1, `OFS_CTRL, 32'h61);
        for (int d = 0; d < 2; d++) begin
            @(posedge pclk);
            run <= 1'b1;
            rev <= d[0];
            repeat (40) @(posedge pclk);
            run <= 1'b0;
            idle(6); apb(0, `OFS_CNT, 0); chk("encoder count", d ? 0 : 10, q);
        end
        $display("test encoder done");
    endtask
    // one rising edge on channel 0 sets its capture flag; one-pulse stops at the update
    task t_cap;
        apb(1, `OFS_CTRL, 0); apb(1, `OFS_CHM, 32'h000000fc); apb(1, `OFS_CLR, 32'h0000001f);
        apb(1, `OFS_CNT, 0); apb(1, `OFS_CTRL, 1);
        @(posedge pclk);
        run <= 1'b1;
        rev <= 1'b0;
        repeat (16) @(posedge pclk);
        run <= 1'b0;
        idle(6); apb(0, `OFS_STS, 0); chk("capture flag", 32'h00000002, q);
        apb(1, `OFS_CTRL, 0); apb(1, `OFS_ARR, 3); apb(1, `OFS_CNT, 0); apb(1, `OFS_CTRL, 32'h9);
        idle(12); apb(0, `OFS_CTRL, 0); chk("one-pulse stop", 32'h00000008, q);
        $display("test capture done");
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // watchdog: tests need well under a thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        finish_test;
    end
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        dbg_halt = 1'b0; run = 1'b0; rev = 1'b0; gate = 1'b1; n_fail = 0; comparisons = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_count;
        t_irq;
        t_pwm;
        t_hold;
        t_enc;
        t_cap;
        finish_test;
    end
endmodule
